// ===== ipr_pkg.sv
// Purpose: Shared constants for the interrupt priority resolver
// Assumes: Eighteen sources numbered 0 to 17, six groups
// Notes:   Register offsets are byte addresses on the 8-bit port
`default_nettype none

package ipr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SRC = 18;
  localparam int NUM_GRP = 6;
  localparam int NUM_LVL = 4;
  localparam int EVT_W   = 3;
  localparam int F5_W    = 5;

  typedef logic [4:0] ipr_num_t;
  typedef logic [1:0] ipr_lvl_t;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_PRIO_LOW   = 8'ha9;
  localparam logic [7:0] OFS_PRIO_HIGH  = 8'hb9;
  localparam logic [7:0] OFS_FLAGS5     = 8'he8;
  localparam logic [7:0] OFS_EVT_STATUS = 8'hf4;
  localparam logic [7:0] OFS_EVT_MASK   = 8'hf5;
  localparam logic [7:0] OFS_SERVICE    = 8'hf6;

  localparam logic [5:0]       RST_PRIO   = 6'h00;
  localparam logic [F5_W-1:0]  RST_FLAGS5 = 5'h00;
  localparam logic [EVT_W-1:0] RST_EVT    = 3'h0;

  // Flag register five fields
  localparam int F5_PORT_TWO    = 0;
  localparam int F5_SERIAL_A_TX = 1;
  localparam int F5_SERIAL_B_TX = 2;
  localparam int F5_PORT_ONE    = 3;
  localparam int F5_WATCHDOG    = 4;

  // Event status fields
  localparam int EVT_VECTOR  = 0;
  localparam int EVT_NESTED  = 1;
  localparam int EVT_BAD_RET = 2;

  // Source numbers backed by flag register five
  localparam ipr_num_t SRC_PORT_TWO    = 5'h06;
  localparam ipr_num_t SRC_SERIAL_A_TX = 5'h07;
  localparam ipr_num_t SRC_SERIAL_B_TX = 5'h0e;
  localparam ipr_num_t SRC_PORT_ONE    = 5'h0f;
  localparam ipr_num_t SRC_WATCHDOG    = 5'h11;

  // ****************************************
  // Polling order and group membership
  // ****************************************
  localparam ipr_num_t POLL_ORDER [NUM_SRC] = '{
    5'h00, 5'h10, 5'h08, 5'h01, 5'h09, 5'h02, 5'h0a, 5'h03, 5'h0b,
    5'h04, 5'h0c, 5'h05, 5'h0d, 5'h06, 5'h07, 5'h0e, 5'h0f, 5'h11};

  localparam logic [2:0] GROUP_OF [NUM_SRC] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2, 3'h0,
    3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h0, 3'h5};

  function automatic ipr_lvl_t level_of(input logic [5:0] hi,
                                        input logic [5:0] lo,
                                        input ipr_num_t   num);
    logic [2:0] g;
    g = GROUP_OF[num];
    return {hi[g], lo[g]};
  endfunction : level_of

endpackage : ipr_pkg

`default_nettype wire

// ===== ipr_sel_if.sv
// Purpose: Carries pending sources and levels to the poll selector
// Assumes: Purely combinational traffic
// Notes:   Winner is valid in the same cycle as the inputs
`timescale 1ns/1ns
`default_nettype none

interface ipr_sel_if;
  logic [ipr_pkg::NUM_SRC-1:0] pending;
  logic [5:0]                  lvl_hi;
  logic [5:0]                  lvl_lo;
  logic                        win_valid;
  ipr_pkg::ipr_num_t           win_num;
  ipr_pkg::ipr_lvl_t           win_lvl;

  modport requester (output pending, lvl_hi, lvl_lo,
                     input  win_valid, win_num, win_lvl);
  modport selector  (input  pending, lvl_hi, lvl_lo,
                     output win_valid, win_num, win_lvl);
endinterface : ipr_sel_if

`default_nettype wire

// ===== ipr_poll_selector.sv
// Purpose: Picks the pending source of highest level, poll order on ties
// Assumes: Pending bits already qualified by the caller
// Notes:   Strict compare keeps the earliest polled source on a tie
`timescale 1ns/1ns
`default_nettype none

module ipr_poll_selector (
  ipr_sel_if.selector sel
);

  logic              found;
  ipr_pkg::ipr_lvl_t best_lvl;
  ipr_pkg::ipr_num_t best_num;
  ipr_pkg::ipr_num_t n;
  ipr_pkg::ipr_lvl_t l;

  // R15: level then poll
  always_comb
  begin
    found    = 1'b0;
    best_lvl = 2'h0;
    best_num = 5'h00;
    n        = 5'h00;
    l        = 2'h0;
    for (int i = 0; i < ipr_pkg::NUM_SRC; i++)
    begin
      n = ipr_pkg::POLL_ORDER[i];
      l = ipr_pkg::level_of(sel.lvl_hi, sel.lvl_lo, n);
      // R12: fixed poll tiebreak
      if (sel.pending[n] && (!found || (l > best_lvl)))
      begin
        found    = 1'b1;
        best_lvl = l;
        best_num = n;
      end
    end
    sel.win_valid = found;
    sel.win_num   = best_num;
    sel.win_lvl   = best_lvl;
  end

endmodule : ipr_poll_selector

`default_nettype wire

// ===== ipr_service_stack.sv
// Purpose: Tracks which priority levels have a routine in service
// Assumes: Return always ends the highest level in service
// Notes:   Pop acts before push when both come in one cycle
`timescale 1ns/1ns
`default_nettype none

module ipr_service_stack #(
  parameter int LEVELS = ipr_pkg::NUM_LVL
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              push,
  input  wire ipr_pkg::ipr_lvl_t push_lvl,
  input  wire logic              pop,
  output logic                   active_valid,
  output ipr_pkg::ipr_lvl_t      active_lvl,
  output logic [LEVELS-1:0]      in_service
);

  logic [LEVELS-1:0] busy_ff;
  logic [LEVELS-1:0] nxt_busy;

  always_comb
  begin
    active_valid = 1'b0;
    active_lvl   = 2'h0;
    for (int i = 0; i < LEVELS; i++)
    begin
      if (busy_ff[i])
      begin
        active_valid = 1'b1;
        active_lvl   = 2'(i);
      end
    end
  end

  always_comb
  begin
    nxt_busy = busy_ff;
    if (pop && active_valid)
      nxt_busy[active_lvl] = 1'b0;
    if (push)
      nxt_busy[push_lvl] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      busy_ff <= '0;
    else
      busy_ff <= nxt_busy;
  end

  assign in_service = busy_ff;

endmodule : ipr_service_stack

`default_nettype wire

// ===== ipr_resolver.sv
// Purpose: Interrupt priority resolver with flag register five
// Assumes: Other sources hold their own flags and present levels
// Notes:   One request is offered to the core at a time
//
// Functional notes
// R01: Flag five bit 4 is watchdog pending, reset 0, software read/write.
// R02: Flag five bit 3 is port one pending, reset 0.
// R03: Flag five bit 2 is shared serial B / audio transmit pending.
// R04: Flag five bit 1 is serial A transmit pending, reset 0.
// R05: Flag five bit 0 is shared port two / USB pending; 7:5 zero.
// R06: Sources form six groups; priority is per group, not per source.
// R07: Four levels per group; every group resets to lowest level.
// R08: High priority register bits 5:0 give group level MSB; 7:6 zero.
// R09: Low priority register bits 5:0 give group level LSB; 7:6 zero.
// R10: Group level is {high bit, low bit}; 00 lowest, 11 highest.
// R11: During service, requests of equal or lower level are not taken.
// R12: Simultaneous equal level requests resolve by fixed polling order.
// R13: Group membership of the eighteen sources is fixed by table.
// R14: Polling order is 0,16,8,1,9,2,10,3,11,4,12,5,13,6,7,14,15,17.
// R15: Highest level wins first, poll order within it; higher preempts.
// R16: Register writes act next cycle; written flag counts as pending.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module ipr_resolver #(
  parameter int NUM_SRC = ipr_pkg::NUM_SRC
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  input  wire logic [NUM_SRC-1:0] src_pending,
  input  wire logic               port_two_req,
  input  wire logic               usb_ctrl_req,
  input  wire logic               serial_a_tx_req,
  input  wire logic               serial_b_tx_req,
  input  wire logic               audio_tx_req,
  input  wire logic               port_one_req,
  input  wire logic               watchdog_req,
  output logic                    vec_valid,
  output ipr_pkg::ipr_num_t       vec_num,
  output ipr_pkg::ipr_lvl_t       vec_level,
  input  wire logic               vec_ack,
  input  wire logic               vec_return,
  output logic [NUM_SRC-1:0]      src_clear,
  output logic                    irq
);

  // ****************************************
  // Types and storage
  // ****************************************
  typedef enum logic [1:0] {
    IPR_IDLE  = 2'b00,
    IPR_OFFER = 2'b01,
    IPR_TAKEN = 2'b11
  } ipr_state_e;

  ipr_state_e                      state_ff;
  ipr_state_e                      nxt_state;
  logic [5:0]                      prio_low_ff;
  logic [5:0]                      prio_high_ff;
  logic [ipr_pkg::F5_W-1:0]        flags5_ff;
  logic [ipr_pkg::F5_W-1:0]        nxt_flags5;
  logic [ipr_pkg::F5_W-1:0]        f5_set;
  logic [ipr_pkg::F5_W-1:0]        f5_clr;
  logic [ipr_pkg::EVT_W-1:0]       evt_status_ff;
  logic [ipr_pkg::EVT_W-1:0]       nxt_evt_status;
  logic [ipr_pkg::EVT_W-1:0]       evt_mask_ff;
  logic [ipr_pkg::EVT_W-1:0]       evt_hit;
  logic [7:0]                      rdata_ff;
  logic [7:0]                      read_mux;
  logic                            vec_valid_ff;
  ipr_pkg::ipr_num_t               vec_num_ff;
  ipr_pkg::ipr_lvl_t               vec_level_ff;
  logic [NUM_SRC-1:0]              src_clear_ff;
  logic [NUM_SRC-1:0]              nxt_src_clear;
  logic                            irq_ff;
  logic [NUM_SRC-1:0]              pending;
  logic                            may_offer;
  logic                            ev_vector;
  logic                            active_valid;
  ipr_pkg::ipr_lvl_t               active_lvl;
  logic [ipr_pkg::NUM_LVL-1:0]     in_service;
  logic                            wr_low;
  logic                            wr_high;
  logic                            wr_flags5;
  logic                            wr_status;
  logic                            wr_mask;

  ipr_sel_if sel_bus ();

  // ****************************************
  // Write decode
  // ****************************************
  assign wr_low    = reg_wr && (reg_addr == ipr_pkg::OFS_PRIO_LOW);
  assign wr_high   = reg_wr && (reg_addr == ipr_pkg::OFS_PRIO_HIGH);
  assign wr_flags5 = reg_wr && (reg_addr == ipr_pkg::OFS_FLAGS5);
  assign wr_status = reg_wr && (reg_addr == ipr_pkg::OFS_EVT_STATUS);
  assign wr_mask   = reg_wr && (reg_addr == ipr_pkg::OFS_EVT_MASK);

  // ****************************************
  // Priority registers
  // ****************************************
  // R07: all groups lowest
  // R09: low bit register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prio_low_ff <= ipr_pkg::RST_PRIO;
    else if (wr_low)
      prio_low_ff <= reg_wdata[5:0];
  end

  // R08: high bit register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prio_high_ff <= ipr_pkg::RST_PRIO;
    else if (wr_high)
      prio_high_ff <= reg_wdata[5:0];
  end

  // ****************************************
  // Flag register five
  // ****************************************
  // Hardware set is applied last so an event on a clear is kept
  always_comb
  begin
    f5_set                             = '0;
    // R05: shared port two flag
    f5_set[ipr_pkg::F5_PORT_TWO]       = port_two_req | usb_ctrl_req;
    // R04: serial A transmit
    f5_set[ipr_pkg::F5_SERIAL_A_TX]    = serial_a_tx_req;
    // R03: shared transmit flag
    f5_set[ipr_pkg::F5_SERIAL_B_TX]    = serial_b_tx_req | audio_tx_req;
    // R02: port one flag
    f5_set[ipr_pkg::F5_PORT_ONE]       = port_one_req;
    // R01: watchdog flag
    f5_set[ipr_pkg::F5_WATCHDOG]       = watchdog_req;
  end

  always_comb
  begin
    f5_clr = '0;
    if (ev_vector)
    begin
      case (vec_num_ff)
        ipr_pkg::SRC_PORT_TWO:    f5_clr[ipr_pkg::F5_PORT_TWO]    = 1'b1;
        ipr_pkg::SRC_SERIAL_A_TX: f5_clr[ipr_pkg::F5_SERIAL_A_TX] = 1'b1;
        ipr_pkg::SRC_SERIAL_B_TX: f5_clr[ipr_pkg::F5_SERIAL_B_TX] = 1'b1;
        ipr_pkg::SRC_PORT_ONE:    f5_clr[ipr_pkg::F5_PORT_ONE]    = 1'b1;
        ipr_pkg::SRC_WATCHDOG:    f5_clr[ipr_pkg::F5_WATCHDOG]    = 1'b1;
        default:                  f5_clr = '0;
      endcase
    end
  end

  // R16: software write after vector clear, before hardware set
  always_comb
  begin
    nxt_flags5 = flags5_ff & ~f5_clr;
    if (wr_flags5)
      nxt_flags5 = reg_wdata[ipr_pkg::F5_W-1:0];
    nxt_flags5 = nxt_flags5 | f5_set;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      flags5_ff <= ipr_pkg::RST_FLAGS5;
    else
      flags5_ff <= nxt_flags5;
  end

  // ****************************************
  // Pending vector and selection
  // ****************************************
  // R16: written flag pends
  always_comb
  begin
    pending                           = src_pending;
    pending[ipr_pkg::SRC_PORT_TWO]    = flags5_ff[ipr_pkg::F5_PORT_TWO];
    pending[ipr_pkg::SRC_SERIAL_A_TX] = flags5_ff[ipr_pkg::F5_SERIAL_A_TX];
    pending[ipr_pkg::SRC_SERIAL_B_TX] = flags5_ff[ipr_pkg::F5_SERIAL_B_TX];
    pending[ipr_pkg::SRC_PORT_ONE]    = flags5_ff[ipr_pkg::F5_PORT_ONE];
    pending[ipr_pkg::SRC_WATCHDOG]    = flags5_ff[ipr_pkg::F5_WATCHDOG];
  end

  // R06: per group levels
  // R10: high bit is MSB
  // R13: membership by table
  // R14: poll order table
  assign sel_bus.pending = pending;
  assign sel_bus.lvl_hi  = prio_high_ff;
  assign sel_bus.lvl_lo  = prio_low_ff;

  ipr_poll_selector u_select (
    .sel (sel_bus.selector)
  );

  ipr_service_stack #(
    .LEVELS (ipr_pkg::NUM_LVL)
  ) u_stack (
    .clock        (clock),
    .rst_n        (rst_n),
    .push         (ev_vector),
    .push_lvl     (vec_level_ff),
    .pop          (vec_return),
    .active_valid (active_valid),
    .active_lvl   (active_lvl),
    .in_service   (in_service)
  );

  // R11: strictly higher only
  // R15: higher level preempts
  assign may_offer = sel_bus.win_valid &&
                     (!active_valid || (sel_bus.win_lvl > active_lvl));

  assign ev_vector = (state_ff == IPR_OFFER) && vec_ack;

  // ****************************************
  // Offer sequence
  // ****************************************
  // Taken state gives peripherals one cycle to drop their level
  always_comb
  begin
    case (state_ff)
      IPR_IDLE:
        nxt_state = may_offer ? IPR_OFFER : IPR_IDLE;
      IPR_OFFER:
        if (vec_ack)
          nxt_state = IPR_TAKEN;
        else if (!may_offer)
          nxt_state = IPR_IDLE;
        else
          nxt_state = IPR_OFFER;
      IPR_TAKEN:
        nxt_state = IPR_IDLE;
      default:
        nxt_state = IPR_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_ff <= IPR_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Offered number tracks the winner until the core takes it
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      vec_valid_ff <= 1'b0;
      vec_num_ff   <= 5'h00;
      vec_level_ff <= 2'h0;
    end
    else
    begin
      vec_valid_ff <= (nxt_state == IPR_OFFER);
      if ((nxt_state == IPR_OFFER) && !ev_vector)
      begin
        vec_num_ff   <= sel_bus.win_num;
        vec_level_ff <= sel_bus.win_lvl;
      end
    end
  end

  always_comb
  begin
    nxt_src_clear = '0;
    if (ev_vector)
      nxt_src_clear[vec_num_ff] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      src_clear_ff <= '0;
    else
      src_clear_ff <= nxt_src_clear;
  end

  // ****************************************
  // Event status, mask and interrupt line
  // ****************************************
  always_comb
  begin
    evt_hit                       = '0;
    evt_hit[ipr_pkg::EVT_VECTOR]  = ev_vector;
    evt_hit[ipr_pkg::EVT_NESTED]  = ev_vector && active_valid;
    evt_hit[ipr_pkg::EVT_BAD_RET] = vec_return && !active_valid;
  end

  // Set beats write-one-clear in the same cycle
  always_comb
  begin
    nxt_evt_status = evt_status_ff;
    if (wr_status)
      nxt_evt_status = nxt_evt_status & ~reg_wdata[ipr_pkg::EVT_W-1:0];
    nxt_evt_status = nxt_evt_status | evt_hit;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      evt_status_ff <= ipr_pkg::RST_EVT;
    else
      evt_status_ff <= nxt_evt_status;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      evt_mask_ff <= ipr_pkg::RST_EVT;
    else if (wr_mask)
      evt_mask_ff <= reg_wdata[ipr_pkg::EVT_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(nxt_evt_status & evt_mask_ff);
  end

  // ****************************************
  // Read port
  // ****************************************
  // Unused upper bits and unmapped addresses read as zero
  always_comb
  begin
    case (reg_addr)
      ipr_pkg::OFS_PRIO_LOW:   read_mux = {2'h0, prio_low_ff};
      ipr_pkg::OFS_PRIO_HIGH:  read_mux = {2'h0, prio_high_ff};
      ipr_pkg::OFS_FLAGS5:     read_mux = {3'h0, flags5_ff};
      ipr_pkg::OFS_EVT_STATUS: read_mux = {5'h00, evt_status_ff};
      ipr_pkg::OFS_EVT_MASK:   read_mux = {5'h00, evt_mask_ff};
      ipr_pkg::OFS_SERVICE:    read_mux = {3'h0, vec_valid_ff, in_service};
      default:                 read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= reg_rd ? read_mux : 8'h00;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_ff;
  assign vec_valid = vec_valid_ff;
  assign vec_num   = vec_num_ff;
  assign vec_level = vec_level_ff;
  assign src_clear = src_clear_ff;
  assign irq       = irq_ff;

endmodule : ipr_resolver

`default_nettype wire

// ===== ipr_resolver_monitor.sv
// Purpose: Port checker for the interrupt priority resolver
// Assumes: One clock, synchronous active low reset
// Notes:   Service levels are rebuilt from ack and return pulses
`timescale 1ns/1ns
`default_nettype none

module ipr_resolver_monitor #(
  parameter int NUM_SRC = ipr_pkg::NUM_SRC
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_rdata,
  input  wire logic               vec_valid,
  input  wire ipr_pkg::ipr_num_t  vec_num,
  input  wire ipr_pkg::ipr_lvl_t  vec_level,
  input  wire logic               vec_ack,
  input  wire logic               vec_return,
  input  wire logic [NUM_SRC-1:0] src_clear,
  input  wire logic               irq
);
  logic [3:0] svc_ff;
  logic [3:0] nxt_svc_ff;
  logic [3:0] top;

  // ****************************************
  // Service levels
  // ****************************************
  // Pop before push, as a return and an ack may share a cycle
  always_comb
  begin
    top = svc_ff[3] ? 4'h8 : svc_ff[2] ? 4'h4 : svc_ff[1] ? 4'h2 : {3'h0, svc_ff[0]};
    nxt_svc_ff = vec_return ? (svc_ff & ~top) : svc_ff;
    if (vec_valid && vec_ack)
      nxt_svc_ff = nxt_svc_ff | (4'h1 << vec_level);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      svc_ff <= 4'h0;
    else
      svc_ff <= nxt_svc_ff;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero outside a read");
  prio_unused_a: assert property (
    reg_rd && (reg_addr == 8'ha9 || reg_addr == 8'hb9) |=> reg_rdata[7:6] == 2'b00)
    else $error("priority unused bits not zero");
  flags_unused_a: assert property (
    reg_rd && reg_addr == 8'he8 |=> reg_rdata[7:5] == 3'h0) else $error("flag bits 7:5 set");
  ack_clear_a: assert property (
    vec_valid && vec_ack |=> !vec_valid && src_clear == (NUM_SRC'(1) << $past(vec_num)))
    else $error("vectored source not cleared");
  clear_pulse_a: assert property (
    src_clear != '0 |=> src_clear == '0) else $error("clear pulse too long");
  reset_quiet_a: assert property (
    $rose(rst_n) |-> !vec_valid && !irq && src_clear == '0) else $error("outputs not quiet");
  no_preempt_a: assert property (
    vec_valid |-> (4'h1 << vec_level) > top) else $error("offer not above service level");
  irq_mask_a: assert property (
    reg_wr && reg_addr == 8'hf5 && reg_wdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("irq high with mask clear");

  cover property (vec_valid && vec_ack && top != 4'h0);
  cover property (vec_return && top == 4'h0);
  cover property ($rose(irq));
endmodule : ipr_resolver_monitor

bind ipr_resolver ipr_resolver_monitor #(.NUM_SRC(NUM_SRC)) i_ipr_resolver_monitor (
  .clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .vec_valid,
  .vec_num, .vec_level, .vec_ack, .vec_return, .src_clear, .irq);

`default_nettype wire

// ===== ipr_core_model.sv
// Purpose: Core side of the vector link, takes offers and returns
// Assumes: Bench enables acks and asks for returns
// Notes:   Ack wait lets the bench play a slow core
`timescale 1ns/1ns
`default_nettype none

module ipr_core_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       vec_valid,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_wait,
  input  wire logic       ret_req,
  output logic            vec_ack,
  output logic            vec_return
);
  logic [3:0] wait_ff;

  // ****************************************
  // Handshake
  // ****************************************
  // Guard on vec_ack avoids a second ack on a stale offer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wait_ff    <= 4'h0;
      vec_ack    <= 1'b0;
      vec_return <= 1'b0;
    end
    else
    begin
      vec_return <= ret_req;
      vec_ack    <= 1'b0;
      wait_ff    <= 4'h0;
      if (vec_valid && ack_en && !vec_ack)
      begin
        if (wait_ff == ack_wait)
          vec_ack <= 1'b1;
        else
          wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : ipr_core_model

`default_nettype wire

// ===== ipr_tb.sv
// Purpose: Self-checking bench for the interrupt priority resolver
// Assumes: Core model acks offers while enabled
// Notes:   Table rows cover level and poll order picks
`timescale 1ns/1ns
`default_nettype none

module testbench;
  typedef struct packed {
    logic [5:0] hi; logic [5:0] lo; logic [17:0] pend; logic [4:0] num; logic [1:0] lvl;
  } ipr_row_s;

  logic              clock       = 1'b0;
  logic              rst_n       = 1'b0;
  logic [7:0]        reg_addr    = 8'h00;
  logic [7:0]        reg_wdata   = 8'h00;
  logic              reg_wr      = 1'b0;
  logic              reg_rd      = 1'b0;
  logic [17:0]       src_pending = 18'h0;
  logic [6:0]        reqv        = 7'h0;
  logic              ack_en      = 1'b0;
  logic [3:0]        ack_wait    = 4'h0;
  logic              ret_req     = 1'b0;
  logic [7:0]        reg_rdata;
  logic [17:0]       src_clear;
  logic              vec_valid, vec_ack, vec_return, irq;
  ipr_pkg::ipr_num_t vec_num;
  ipr_pkg::ipr_lvl_t vec_level;
  int                error_cnt   = 0;
  int                comparisons = 0;
  int                cycles      = 0;
  logic [2:0]        bmap [7]    = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
  ipr_row_s          rows [10]   = '{
    '{6'h00, 6'h00, 18'h10100, 5'h10, 2'h0}, '{6'h00, 6'h00, 18'h00202, 5'h01, 2'h0},
    '{6'h00, 6'h00, 18'h00408, 5'h0a, 2'h0}, '{6'h00, 6'h00, 18'h02020, 5'h05, 2'h0},
    '{6'h20, 6'h00, 18'h00021, 5'h05, 2'h2}, '{6'h21, 6'h01, 18'h00021, 5'h00, 2'h3},
    '{6'h00, 6'h08, 18'h00810, 5'h0b, 2'h1}, '{6'h10, 6'h00, 18'h01200, 5'h0c, 2'h2},
    '{6'h00, 6'h00, 18'h10810, 5'h10, 2'h0}, '{6'h01, 6'h00, 18'h00102, 5'h08, 2'h2}};

  ipr_resolver i_ipr_resolver (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_pending(src_pending), .port_two_req(reqv[0]), .usb_ctrl_req(reqv[1]),
    .serial_a_tx_req(reqv[2]), .serial_b_tx_req(reqv[3]), .audio_tx_req(reqv[4]),
    .port_one_req(reqv[5]), .watchdog_req(reqv[6]), .vec_valid(vec_valid),
    .vec_num(vec_num), .vec_level(vec_level), .vec_ack(vec_ack), .vec_return(vec_return),
    .src_clear(src_clear), .irq(irq));
  ipr_core_model i_ipr_core_model (.clock(clock), .rst_n(rst_n), .vec_valid(vec_valid),
    .ack_en(ack_en), .ack_wait(ack_wait), .ret_req(ret_req), .vec_ack(vec_ack),
    .vec_return(vec_return));

  // ****************************************
  // Tasks
  // ****************************************
  always #5 clock = ~clock;

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr

  // Sampled at the edge, so the value is that of the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(18'(reg_rdata), 18'(exp));
  endtask : rd_chk

  task automatic wait_valid;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      if (vec_valid === 1'b1)
        break;
    end
  endtask : wait_valid

  task automatic take(input logic [17:0] exp);
    ack_en <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clock);
      if (src_clear !== 18'h0)
        break;
    end
    ack_en <= 1'b0;
    chk(src_clear, exp);
  endtask : take

  task automatic ret;
    ret_req <= 1'b1;
    @(posedge clock);
    ret_req <= 1'b0;
    @(posedge clock);
  endtask : ret

  task automatic conclude;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_chk(8'he8, 8'h00);
    foreach (rows[i])
    begin
      wr(8'hb9, {2'b00, rows[i].hi});
      wr(8'ha9, {2'b00, rows[i].lo});
      src_pending <= rows[i].pend;
      wait_valid();
      chk(18'(vec_num), 18'(rows[i].num));
      chk(18'(vec_level), 18'(rows[i].lvl));
      src_pending <= 18'h0;
      repeat (2) @(posedge clock);
    end
    foreach (bmap[k])
    begin
      reqv <= 7'h01 << k;
      @(posedge clock);
      reqv <= 7'h00;
      @(posedge clock);
      rd_chk(8'he8, 8'h01 << bmap[k]);
      wr(8'he8, 8'h00);
    end
    wr(8'hb9, 8'hff);
    rd_chk(8'hb9, 8'h3f);
    wr(8'ha9, 8'hff);
    rd_chk(8'ha9, 8'h3f);
    wr(8'hb9, 8'h00);
    wr(8'ha9, 8'h00);
    wr(8'he8, 8'hff);
    rd_chk(8'he8, 8'h1f);
    chk(18'(vec_num), 18'h06);
    wr(8'he8, 8'h10);
    wr(8'hf5, 8'h07);
    ack_wait <= 4'h3;
    take(18'h20000);
    rd_chk(8'he8, 8'h00);
    rd_chk(8'hf6, 8'h01);
    chk(18'(irq), 18'h1);
    src_pending <= 18'h00001;
    repeat (4) @(posedge clock);
    chk(18'(vec_valid), 18'h0);
    wr(8'hb9, 8'h01);
    wait_valid();
    chk(18'({vec_num, vec_level}), 18'h02);
    ack_wait <= 4'h0;
    take(18'h00001);
    src_pending <= 18'h0;
    rd_chk(8'hf6, 8'h05);
    rd_chk(8'hf4, 8'h03);
    repeat (3) ret();
    rd_chk(8'hf6, 8'h00);
    rd_chk(8'hf4, 8'h07);
    wr(8'hf4, 8'h07);
    wr(8'hf5, 8'h00);
    ret();
    rd_chk(8'hf4, 8'h04);
    chk(18'(irq), 18'h0);
    wr(8'h55, 8'hff);
    rd_chk(8'h55, 8'h00);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_chk(8'hb9, 8'h00);
    rd_chk(8'ha9, 8'h00);
    conclude();
  end
endmodule : testbench

`default_nettype wire
